/* opmix_params.svh */
// Offsets, field positions and reset values of the output path registers.
// Assumes word indices; the byte address on the bus is four times the index.
`ifndef OPMIX_PARAMS_SVH
`define OPMIX_PARAMS_SVH
// Register indices
`define OPMIX_IDX_PWR2   7'h09
`define OPMIX_IDX_OUTEN  7'h0a
`define OPMIX_IDX_LMIX   7'h58
`define OPMIX_IDX_RMIX   7'h59
`define OPMIX_IDX_THIRD  7'h5c
`define OPMIX_IDX_FOURTH 7'h5d
`define OPMIX_IDX_LGAIN  7'h60
`define OPMIX_IDX_RGAIN  7'h61
`define OPMIX_IDX_HPL    7'h68
`define OPMIX_IDX_HPR    7'h69
`define OPMIX_IDX_SECL   7'h70
`define OPMIX_IDX_SECR   7'h71
// Field positions
`define OPMIX_MIRROR_BIT 15
`define OPMIX_SEL_LPGA   0
`define OPMIX_SEL_RPGA   1
`define OPMIX_SEL_AUXL   2
`define OPMIX_SEL_AUXR   3
`define OPMIX_SEL_DACL   11
`define OPMIX_SEL_DACR   12
`define OPMIX_ROUTE_BIT  0
// Gain field LSBs: left mixer 1/5/9, right mixer 1/5/13
`define OPMIX_GAIN_LSB0  1
`define OPMIX_GAIN_LSB1  5
`define OPMIX_GAIN_LSB2  9
`define OPMIX_GAIN_LSB2R 13
// Reset values and bus answers
`define OPMIX_GAIN_RST   3'h0
`define OPMIX_RESP_OKAY  2'h0
`define OPMIX_RESP_SLV   2'h2
`endif

/* opmix_pkg.sv */
// Types shared by the output path register block.
// Assumes opmix_params.svh for the numeric values.
package opmix_pkg;
  typedef logic [6:0]  opmix_idx_t;   // Register word index
  typedef logic [15:0] opmix_word_t;  // Register contents
  typedef logic [2:0]  opmix_gain_t;  // Path gain code
  // Control state seen by the analogue output path
  typedef struct packed {
    logic [5:0]  drive_en;   // hp L/R, second L/R, third, fourth
    logic [1:0]  mix_en;     // Left, right output mixer
    logic [4:0]  left_sel;   // dac_r, dac_l, aux_l, pga_r, pga_l
    logic [4:0]  right_sel;  // dac_r, dac_l, aux, pga_r, pga_l
    logic [17:0] gain;       // Six 3-bit path gains, left mixer low
    logic        third_src;  // Left mixer feeds third mixer
    logic        fourth_src; // Right mixer feeds fourth mixer
  } opmix_ctrl_s;
endpackage

/* opmix_regs.sv */
// Output path enable and mixer select registers behind an AXI4-Lite slave.
// Assumes one clock, an active-high async reset, and 16-bit registers
// in the low half of each 32-bit word.
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/100ps
`include "opmix_params.svh"
module opmix_regs
  import opmix_pkg::*;
(
  input  wire logic        sys_clk,        // 40 MHz clock
  input  wire logic        rst,            // Async reset, active high
  input  wire logic [8:0]  s_axi_awaddr,   // Write address
  input  wire logic        s_axi_awvalid,  // Write address valid
  output logic             s_axi_awready,  // Write address ready
  input  wire logic [31:0] s_axi_wdata,    // Write data
  input  wire logic [3:0]  s_axi_wstrb,    // Write byte strobes
  input  wire logic        s_axi_wvalid,   // Write data valid
  output logic             s_axi_wready,   // Write data ready
  output logic [1:0]       s_axi_bresp,    // Write response
  output logic             s_axi_bvalid,   // Write response valid
  input  wire logic        s_axi_bready,   // Write response ready
  input  wire logic [8:0]  s_axi_araddr,   // Read address
  input  wire logic        s_axi_arvalid,  // Read address valid
  output logic             s_axi_arready,  // Read address ready
  output logic [31:0]      s_axi_rdata,    // Read data
  output logic [1:0]       s_axi_rresp,    // Read response
  output logic             s_axi_rvalid,   // Read data valid
  input  wire logic        s_axi_rready,   // Read data ready
  output opmix_ctrl_s      ctrl            // Output path control
);

  // Enable table: drivers 0..5 then mixers 6..7
  localparam opmix_idx_t PIDX [8] = '{
    `OPMIX_IDX_OUTEN, `OPMIX_IDX_OUTEN, `OPMIX_IDX_OUTEN, `OPMIX_IDX_OUTEN,
    `OPMIX_IDX_PWR2, `OPMIX_IDX_PWR2, `OPMIX_IDX_PWR2, `OPMIX_IDX_PWR2};
  localparam int PBIT [8] = '{0, 1, 2, 3, 4, 5, 0, 1};
  localparam opmix_idx_t MIDX [8] = '{
    `OPMIX_IDX_HPL, `OPMIX_IDX_HPR, `OPMIX_IDX_SECL, `OPMIX_IDX_SECR,
    `OPMIX_IDX_THIRD, `OPMIX_IDX_FOURTH, `OPMIX_IDX_LMIX, `OPMIX_IDX_RMIX};
  // Gain table: three left-mixer paths, then three right-mixer paths
  localparam opmix_idx_t GIDX [6] = '{
    `OPMIX_IDX_LGAIN, `OPMIX_IDX_LGAIN, `OPMIX_IDX_LGAIN,
    `OPMIX_IDX_RGAIN, `OPMIX_IDX_RGAIN, `OPMIX_IDX_RGAIN};
  localparam int GLSB [6] = '{
    `OPMIX_GAIN_LSB0, `OPMIX_GAIN_LSB1, `OPMIX_GAIN_LSB2,
    `OPMIX_GAIN_LSB0, `OPMIX_GAIN_LSB1, `OPMIX_GAIN_LSB2R};

  logic [7:0]  en_reg;         // Shared enable storage
  logic [4:0]  lsel_reg;       // Left mixer sources
  logic [4:0]  rsel_reg;       // Right mixer sources
  opmix_gain_t gain_reg [6];   // Path gains
  logic        third_reg;      // Third mixer source
  logic        fourth_reg;     // Fourth mixer source
  opmix_idx_t  aw_idx_reg;     // Held write index
  logic [15:0] wdata_reg;      // Held write data
  logic [1:0]  wstrb_reg;      // Held low-half strobes
  logic        wr_fire;        // Commit of a write
  opmix_word_t wr_word;        // Merged write word

  // Assemble a register's read value; undefined bits stay zero
  function automatic opmix_word_t read_word(input opmix_idx_t idx);
    opmix_word_t w;
    w = '0;
    // Primary and mirror locations of an enable read the same flop
    for (int i = 0; i < 8; i++) begin
      if (idx == PIDX[i]) w[PBIT[i]] = en_reg[i];
      if (idx == MIDX[i]) w[`OPMIX_MIRROR_BIT] = en_reg[i];
    end
    for (int i = 0; i < 6; i++) begin
      if (idx == GIDX[i]) w[GLSB[i] +: 3] = gain_reg[i];
    end
    if (idx == `OPMIX_IDX_LMIX) begin
      w[`OPMIX_SEL_LPGA] = lsel_reg[0];
      w[`OPMIX_SEL_RPGA] = lsel_reg[1];
      w[`OPMIX_SEL_AUXL] = lsel_reg[2];
      w[`OPMIX_SEL_DACL] = lsel_reg[3];
      w[`OPMIX_SEL_DACR] = lsel_reg[4];
    end
    if (idx == `OPMIX_IDX_RMIX) begin
      w[`OPMIX_SEL_LPGA] = rsel_reg[0];
      w[`OPMIX_SEL_RPGA] = rsel_reg[1];
      w[`OPMIX_SEL_AUXR] = rsel_reg[2];
      w[`OPMIX_SEL_DACL] = rsel_reg[3];
      w[`OPMIX_SEL_DACR] = rsel_reg[4];
    end
    if (idx == `OPMIX_IDX_THIRD) w[`OPMIX_ROUTE_BIT] = third_reg;
    if (idx == `OPMIX_IDX_FOURTH) w[`OPMIX_ROUTE_BIT] = fourth_reg;
    return w;
  endfunction

  // Whether an index names a register of this block
  // Used for the response code only; storage decode is per register
  function automatic logic mapped(input opmix_idx_t idx);
    unique case (idx)
      `OPMIX_IDX_PWR2, `OPMIX_IDX_OUTEN, `OPMIX_IDX_LMIX, `OPMIX_IDX_RMIX,
      `OPMIX_IDX_THIRD, `OPMIX_IDX_FOURTH, `OPMIX_IDX_LGAIN, `OPMIX_IDX_RGAIN,
      `OPMIX_IDX_HPL, `OPMIX_IDX_HPR, `OPMIX_IDX_SECL,
      `OPMIX_IDX_SECR: return 1'b1;
      default:          return 1'b0;
    endcase
  endfunction

  // Both halves held and no response pending
  // Waiting on a pending response keeps bresp from being overwritten
  assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  // Strobe merge keeps unstrobed bytes of the old value
  // Merge starts from what a read returns, so undefined bits
  // stay zero after any partial write
  always_comb begin
    wr_word = read_word(aw_idx_reg);
    if (wstrb_reg[0]) wr_word[7:0] = wdata_reg[7:0];
    if (wstrb_reg[1]) wr_word[15:8] = wdata_reg[15:8];
  end

  // Write address channel; ready drops while an address is held
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      aw_idx_reg    <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_idx_reg    <= s_axi_awaddr[8:2];
    end else if (wr_fire) begin
      s_axi_awready <= 1'b1;
    end
  end

  // Write data channel; upper half is dropped, registers are 16 bits
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_axi_wready <= 1'b1;
      wdata_reg    <= '0;
      wstrb_reg    <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      wdata_reg    <= s_axi_wdata[15:0];
      wstrb_reg    <= s_axi_wstrb[1:0];
    end else if (wr_fire) begin
      s_axi_wready <= 1'b1;
    end
  end

  // Write response; unmapped writes change nothing and answer SLVERR
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `OPMIX_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= mapped(aw_idx_reg) ? `OPMIX_RESP_OKAY : `OPMIX_RESP_SLV;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel; one-cycle answer, next address after the data is taken
  // Data is built from the stored bits, so both aliases always agree
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `OPMIX_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {16'h0000, read_word(s_axi_araddr[8:2])};
      s_axi_rresp   <= mapped(s_axi_araddr[8:2]) ? `OPMIX_RESP_OKAY : `OPMIX_RESP_SLV;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  // Assertion clock and reset; declared ahead of the per-bit checks below
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // One shared bit per enable, written through either location
  for (genvar g = 0; g < 8; g++) begin : g_en
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        en_reg[g] <= 1'b0;
      end else if (wr_fire && aw_idx_reg == PIDX[g]) begin
        en_reg[g] <= wr_word[PBIT[g]];
      end else if (wr_fire && aw_idx_reg == MIDX[g]) begin
        en_reg[g] <= wr_word[`OPMIX_MIRROR_BIT];
      end
    end
    AST_EN_MIRROR: assert property (wr_fire && aw_idx_reg == MIDX[g]
      |=> en_reg[g] == $past(wr_word[`OPMIX_MIRROR_BIT])) else $error("mirror write lost");
    AST_EN_PRIMARY: assert property (wr_fire && aw_idx_reg == PIDX[g]
      |=> en_reg[g] == $past(wr_word[PBIT[g]])) else $error("primary write lost");
  end

  // Path gains, each mixer with its own copy
  // Record mixer gains live elsewhere and are never written here
  for (genvar g = 0; g < 6; g++) begin : g_gain
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        gain_reg[g] <= `OPMIX_GAIN_RST;
      end else if (wr_fire && aw_idx_reg == GIDX[g]) begin
        gain_reg[g] <= wr_word[GLSB[g] +: 3];
      end
    end
  end

  // Mixer source selects
  // Positions differ: left aux select at bit 2, right aux at bit 3
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lsel_reg <= '0;
      rsel_reg <= '0;
    end else if (wr_fire && aw_idx_reg == `OPMIX_IDX_LMIX) begin
      lsel_reg <= {wr_word[`OPMIX_SEL_DACR], wr_word[`OPMIX_SEL_DACL],
                   wr_word[`OPMIX_SEL_AUXL], wr_word[`OPMIX_SEL_RPGA],
                   wr_word[`OPMIX_SEL_LPGA]};
    end else if (wr_fire && aw_idx_reg == `OPMIX_IDX_RMIX) begin
      rsel_reg <= {wr_word[`OPMIX_SEL_DACR], wr_word[`OPMIX_SEL_DACL],
                   wr_word[`OPMIX_SEL_AUXR], wr_word[`OPMIX_SEL_RPGA],
                   wr_word[`OPMIX_SEL_LPGA]};
    end
  end

  // Third and fourth mixers take their own source routing
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      third_reg  <= 1'b0;
      fourth_reg <= 1'b0;
    end else if (wr_fire && aw_idx_reg == `OPMIX_IDX_THIRD) begin
      third_reg  <= wr_word[`OPMIX_ROUTE_BIT];
    end else if (wr_fire && aw_idx_reg == `OPMIX_IDX_FOURTH) begin
      fourth_reg <= wr_word[`OPMIX_ROUTE_BIT];
    end
  end

  // Control outputs are the flops themselves
  // No logic between flops and outputs keeps the analogue side glitch free
  assign ctrl.drive_en   = en_reg[5:0];
  assign ctrl.mix_en     = en_reg[7:6];
  assign ctrl.left_sel   = lsel_reg;
  assign ctrl.right_sel  = rsel_reg;
  assign ctrl.gain       = {gain_reg[5], gain_reg[4], gain_reg[3],
                            gain_reg[2], gain_reg[1], gain_reg[0]};
  assign ctrl.third_src  = third_reg;
  assign ctrl.fourth_src = fourth_reg;

  // Checks on reset state, both bus paths and per-mixer independence
  // Reset check runs on the first edge after rst falls, so it opts out of the default disable
  AST_RESET_OFF: assert property (disable iff (1'b0) $fell(rst) |-> ctrl == '0)
    else $error("state not cleared by reset");
  // Left select bits land on their own fields; bit 15 goes to the mixer enable, the rest are dropped
  AST_LSEL_WRITE: assert property (wr_fire && aw_idx_reg == `OPMIX_IDX_LMIX
    |=> lsel_reg[4:3] == $past(wr_word[12:11]) && lsel_reg[2:0] == $past(wr_word[2:0]))
    else $error("left select write wrong");
  // Right mixer aux select sits one bit higher than the left one
  AST_RSEL_WRITE: assert property (wr_fire && aw_idx_reg == `OPMIX_IDX_RMIX
    |=> rsel_reg[4:3] == $past(wr_word[12:11]) && rsel_reg[2] == $past(wr_word[3])
        && rsel_reg[1:0] == $past(wr_word[1:0])) else $error("right select write wrong");
  // A left gain write must leave the right mixer's copy alone
  AST_GAIN_SEPARATE: assert property (wr_fire && aw_idx_reg == `OPMIX_IDX_LGAIN
    |=> $stable(ctrl.gain[17:9]) && ctrl.gain[8:6] == $past(wr_word[11:9]))
    else $error("left gain write disturbed right");
  // Mirror read shows the enable as it stood when the address was taken
  AST_MIX_ALIAS: assert property (s_axi_arvalid && s_axi_arready
    && s_axi_araddr[8:2] == `OPMIX_IDX_LMIX |=> s_axi_rdata[15] == $past(ctrl.mix_en[0]))
    else $error("mixer mirror read wrong");
  // Unmapped reads answer zero with an error code
  AST_UNMAPPED: assert property (s_axi_arvalid && s_axi_arready && !mapped(s_axi_araddr[8:2])
    |=> s_axi_rvalid && s_axi_rdata == '0 && s_axi_rresp == `OPMIX_RESP_SLV)
    else $error("unmapped read answer wrong");
  // Registers are 16 bits, so the upper half of a read is always zero
  AST_UPPER_ZERO: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == '0)
    else $error("upper read bits not zero");
  // Every commit answers on the next edge and frees both write channels
  AST_B_AFTER: assert property (wr_fire
    |=> s_axi_bvalid && s_axi_awready && s_axi_wready) else $error("write response missing");
  // Third and fourth mixer routes are written apart from each other
  AST_THIRD_ROUTE: assert property (wr_fire && aw_idx_reg == `OPMIX_IDX_THIRD
    |=> third_reg == $past(wr_word[`OPMIX_ROUTE_BIT]) && $stable(fourth_reg))
    else $error("third route write wrong");
  AST_FOURTH_ROUTE: assert property (wr_fire && aw_idx_reg == `OPMIX_IDX_FOURTH
    |=> fourth_reg == $past(wr_word[`OPMIX_ROUTE_BIT]) && $stable(third_reg))
    else $error("fourth route write wrong");

  // Main scenarios worth seeing at least once
  COV_MIRROR_WRITE: cover property (wr_fire && aw_idx_reg == `OPMIX_IDX_HPL);
  COV_UNMAPPED: cover property (wr_fire && !mapped(aw_idx_reg));
  COV_BACK2BACK: cover property (s_axi_bvalid && s_axi_bready ##1 s_axi_bvalid);
  COV_PART_STROBE: cover property (wr_fire && wstrb_reg != 2'b11);
  COV_ROUTE: cover property (wr_fire && aw_idx_reg == `OPMIX_IDX_THIRD);

endmodule // opmix_regs

/* tb_top.sv */
// Self-checking bench for the output path register block.
// Assumes opmix_pkg and opmix_params.svh are compiled first; AXI4-Lite only.
`timescale 1ns/100ps
`include "opmix_params.svh"
module tb_top
  import opmix_pkg::*;
();
  logic        sys_clk       = 1'b0;   // 40 MHz clock
  logic        rst           = 1'b1;   // Async reset
  logic [8:0]  s_axi_awaddr  = 9'h000; // Write address
  logic        s_axi_awvalid = 1'b0;   // Write address valid
  logic        s_axi_awready;          // Write address ready
  logic [31:0] s_axi_wdata   = 32'h0;  // Write data
  logic [3:0]  s_axi_wstrb   = 4'hf;   // Byte strobes, all on by default
  logic        s_axi_wvalid  = 1'b0;   // Write data valid
  logic        s_axi_wready;           // Write data ready
  logic [1:0]  s_axi_bresp;            // Write response
  logic        s_axi_bvalid;           // Write response valid
  logic        s_axi_bready  = 1'b0;   // Write response ready
  logic [8:0]  s_axi_araddr  = 9'h000; // Read address
  logic        s_axi_arvalid = 1'b0;   // Read address valid
  logic        s_axi_arready;          // Read address ready
  logic [31:0] s_axi_rdata;            // Read data
  logic [1:0]  s_axi_rresp;            // Read response
  logic        s_axi_rvalid;           // Read data valid
  logic        s_axi_rready  = 1'b0;   // Read data ready
  opmix_ctrl_s ctrl;                   // Control outputs
  int          err_total     = 0;      // Mismatches
  int          n_tests       = 0;      // Comparisons
  localparam logic [1:0] OK = `OPMIX_RESP_OKAY;
  localparam logic [1:0] SE = `OPMIX_RESP_SLV;
  opmix_idx_t  map_l [12] = '{`OPMIX_IDX_PWR2, `OPMIX_IDX_OUTEN, `OPMIX_IDX_LMIX, `OPMIX_IDX_RMIX,
    `OPMIX_IDX_THIRD, `OPMIX_IDX_FOURTH, `OPMIX_IDX_LGAIN, `OPMIX_IDX_RGAIN,
    `OPMIX_IDX_HPL, `OPMIX_IDX_HPR, `OPMIX_IDX_SECL, `OPMIX_IDX_SECR};

  opmix_regs dut (.sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .ctrl);

  // Free-running clock, 25 ns period
  always #12.5 sys_clk = ~sys_clk;

  // Byte address is four times the word index
  function automatic logic [8:0] ba(input opmix_idx_t i);
    return {i, 2'b00};
  endfunction

  // Verdict and stop
  task automatic end_of_test();
    if (err_total == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Any compare of a value, response or control word
  task automatic chk(input logic [37:0] g, input logic [37:0] e, input string m);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  // Hang cut short
  task automatic tmo();
    err_total++;
    $display("BAD %0t handshake timeout", $time);
    end_of_test();
  endtask

  // Write one word; address and data offered together, response judged
  task automatic axw(input opmix_idx_t i, input logic [15:0] d, input logic [1:0] er);
    int   n;
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr  <= ba(i);
    s_axi_wdata   <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (n = 0; n < 20 && !(aw && w); n++) begin
      @(negedge sys_clk);
      aw = aw | s_axi_awready;
      w  = w | s_axi_wready;
      @(posedge sys_clk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    if (!(aw && w)) tmo();
    n = 0;
    do begin @(negedge sys_clk); n++; end while (s_axi_bvalid !== 1'b1 && n < 20);
    if (s_axi_bvalid !== 1'b1) tmo();
    chk(s_axi_bresp, er, "bresp");
    @(posedge sys_clk);
    s_axi_bready <= 1'b0;
    @(posedge sys_clk);
  endtask

  // Read one word and judge data and response
  task automatic axr(input opmix_idx_t i, input logic [15:0] ed, input logic [1:0] er);
    int n;
    s_axi_araddr  <= ba(i);
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    n = 0;
    do begin @(negedge sys_clk); n++; end while (s_axi_arready !== 1'b1 && n < 20);
    if (s_axi_arready !== 1'b1) tmo();
    @(posedge sys_clk);
    s_axi_arvalid <= 1'b0;
    n = 0;
    do begin @(negedge sys_clk); n++; end while (s_axi_rvalid !== 1'b1 && n < 20);
    if (s_axi_rvalid !== 1'b1) tmo();
    chk(s_axi_rdata, {16'h0000, ed}, "rdata");
    chk(s_axi_rresp, er, "rresp");
    @(posedge sys_clk);
    s_axi_rready <= 1'b0;
    @(posedge sys_clk);
  endtask

  // Everything clear after reset
  task automatic t_reset();
    chk(ctrl, 38'h0, "ctrl reset");
    foreach (map_l[k]) axr(map_l[k], 16'h0000, OK);
  endtask

  // Output enables and their per-output mirrors
  task automatic t_outen();
    axw(`OPMIX_IDX_OUTEN, 16'hffff, OK);
    axr(`OPMIX_IDX_OUTEN, 16'h000f, OK);
    axr(`OPMIX_IDX_HPL, 16'h8000, OK);
    axr(`OPMIX_IDX_SECR, 16'h8000, OK);
    axw(`OPMIX_IDX_HPR, 16'h0000, OK);
    axr(`OPMIX_IDX_OUTEN, 16'h000d, OK);
    chk(ctrl.drive_en, 6'h0d, "drive_en");
  endtask

  // Power register enables and their mirrors
  task automatic t_pwr();
    axw(`OPMIX_IDX_PWR2, 16'hffff, OK);
    axr(`OPMIX_IDX_PWR2, 16'h0033, OK);
    axr(`OPMIX_IDX_FOURTH, 16'h8000, OK);
    axr(`OPMIX_IDX_LMIX, 16'h8000, OK);
    axr(`OPMIX_IDX_RMIX, 16'h8000, OK);
    chk(ctrl.mix_en, 2'h3, "mix_en");
    axw(`OPMIX_IDX_THIRD, 16'h0000, OK);
    axw(`OPMIX_IDX_RMIX, 16'h0000, OK);
    axr(`OPMIX_IDX_PWR2, 16'h0021, OK);
    chk(ctrl.drive_en, 6'h2d, "drive_en");
    chk(ctrl.mix_en, 2'h1, "mix_en");
  endtask

  // Source selects of both output mixers
  task automatic t_sel();
    axw(`OPMIX_IDX_LMIX, 16'h7fff, OK);
    axr(`OPMIX_IDX_LMIX, 16'h1807, OK);
    axw(`OPMIX_IDX_RMIX, 16'h7fff, OK);
    axr(`OPMIX_IDX_RMIX, 16'h180b, OK);
    axr(`OPMIX_IDX_PWR2, 16'h0020, OK);
    chk(ctrl.left_sel, 5'h1f, "left_sel");
    chk(ctrl.right_sel, 5'h1f, "right_sel");
    axw(`OPMIX_IDX_RMIX, 16'h0802, OK);
    chk(ctrl.right_sel, 5'h0a, "right_sel");
    chk(ctrl.left_sel, 5'h1f, "left_sel");
    // Partial strobes keep the other byte of the shared bits
    s_axi_wstrb <= 4'h2;
    axw(`OPMIX_IDX_LMIX, 16'h80ff, OK);
    axr(`OPMIX_IDX_LMIX, 16'h8007, OK);
    s_axi_wstrb <= 4'h1;
    axw(`OPMIX_IDX_LMIX, 16'h1800, OK);
    s_axi_wstrb <= 4'hf;
    chk(ctrl.left_sel, 5'h00, "left_sel");
    chk(ctrl.mix_en, 2'h1, "mix_en");
  endtask

  // Third and fourth mixer routes set apart
  task automatic t_route();
    axw(`OPMIX_IDX_THIRD, 16'h0001, OK);
    axr(`OPMIX_IDX_THIRD, 16'h0001, OK);
    chk(ctrl.third_src, 1'b1, "third_src");
    chk(ctrl.fourth_src, 1'b0, "fourth_src");
    axr(`OPMIX_IDX_FOURTH, 16'h8000, OK);
    axw(`OPMIX_IDX_FOURTH, 16'h8001, OK);
    chk(ctrl.fourth_src, 1'b1, "fourth_src");
    chk(ctrl.third_src, 1'b1, "third_src");
    chk(ctrl.drive_en, 6'h2d, "drive_en");
  endtask

  // Reset in mid-run clears everything written so far
  task automatic t_rerst();
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    chk(ctrl, 38'h0, "ctrl rerst");
    axr(`OPMIX_IDX_OUTEN, 16'h0000, OK);
    axr(`OPMIX_IDX_RGAIN, 16'h0000, OK);
  endtask

  // Per-mixer gain fields stay apart
  task automatic t_gain();
    axw(`OPMIX_IDX_LGAIN, 16'hffff, OK);
    axr(`OPMIX_IDX_LGAIN, 16'h0eee, OK);
    axw(`OPMIX_IDX_RGAIN, 16'hffff, OK);
    axr(`OPMIX_IDX_RGAIN, 16'he0ee, OK);
    axw(`OPMIX_IDX_LGAIN, 16'h0002, OK);
    chk(ctrl.gain, 18'h3fe01, "gain");
    axr(`OPMIX_IDX_RGAIN, 16'he0ee, OK);
  endtask

  // Unmapped places refuse and change nothing
  task automatic t_unmap();
    axw(7'h0b, 16'hffff, SE);
    axw(7'h7f, 16'hffff, SE);
    axr(7'h7f, 16'h0000, SE);
    axr(`OPMIX_IDX_OUTEN, 16'h000d, OK);
  endtask

  // Main sequence: reset for six cycles, then scenarios
  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_outen();
    t_pwr();
    t_sel();
    t_gain();
    t_unmap();
    t_route();
    t_rerst();
    end_of_test();
  end
endmodule // tb_top
